// ==== common/hbc_pkg.sv ====
// Shared constants and types for the host bus control block.
// Assumes a host bus clock domain and a core clock domain, both reset by arst_n.
package hbc_pkg;

  // Widths of the multiplexed lanes and of the select inputs.
  localparam int BYTE_W = 8;
  localparam int RS_W = 4;
  localparam int ADDR_W = 16;

  // Reset levels of the pins facing the host bus.
  localparam logic DIR_RST = 1'h1;
  localparam logic OWN_N_RST = 1'h1;
  localparam logic OE_N_RST = 1'h1;
  localparam logic CS_N_RST = 1'h1;
  localparam logic BHE_N_RST = 1'h1;
  localparam logic [RS_W-1:0] RS_RST = 4'h0;
  localparam logic [BYTE_W-1:0] BYTE_RST = 8'h0;

  // Levels of the bus style strap.
  localparam logic STYLE_X86 = 1'h1;

  // Direction levels of the external data buffers.
  localparam logic DIR_OUT = 1'h1;
  localparam logic DIR_IN = 1'h0;

  // States of the bus mastership sequence.
  typedef enum logic [2:0] {
    HBC_IDLE,
    HBC_REQUEST,
    HBC_LATCH,
    HBC_TRANSFER,
    HBC_RELEASE
  } hbc_state_t;

endpackage : hbc_pkg

// ==== hw/hbc_host_ctrl.sv ====
// Host bus control signals: bus hold handshake, buffer direction, interrupt vector, parity and select latch.
// Assumes core requests are levels on ref_clk and the host bus pins run on host_bus_clock.
`timescale 1ns/10ps
module hbc_host_ctrl #(
  parameter int AW = hbc_pkg::ADDR_W
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic host_bus_clock,
  input wire logic dma_req,
  input wire logic dma_write,
  input wire logic [AW-1:0] dma_addr,
  input wire logic direct_io_access,
  input wire logic dio_write,
  input wire logic irq_pending,
  input wire logic [hbc_pkg::BYTE_W-1:0] irq_vector,
  output logic dma_granted,
  output logic irq_acked,
  input wire logic bus_style_strap,
  input wire logic hold_acknowledge_in,
  input wire logic interrupt_acknowledge_in,
  input wire logic address_strobe_in,
  input wire logic chip_select_n,
  input wire logic [hbc_pkg::RS_W-1:0] register_select_lines,
  input wire logic byte_high_enable_n,
  input wire logic [hbc_pkg::BYTE_W-1:0] addr_data_high_byte_in,
  input wire logic [hbc_pkg::BYTE_W-1:0] addr_data_low_byte_in,
  input wire logic parity_high_lane_in,
  input wire logic parity_low_lane_in,
  output logic [hbc_pkg::BYTE_W-1:0] addr_data_high_byte_out,
  output logic [hbc_pkg::BYTE_W-1:0] addr_data_low_byte_out,
  output logic parity_high_lane_out,
  output logic parity_low_lane_out,
  output logic lanes_oe_n,
  output logic buffer_direction_out,
  output logic hold_request_out,
  output logic interrupt_request_out,
  output logic bus_owned_n,
  output logic address_latch_pulse,
  output logic x86_mode,
  output logic parity_error,
  output logic latched_cs_n,
  output logic [hbc_pkg::RS_W-1:0] latched_rs,
  output logic latched_bhe_n
);

  localparam int BW = hbc_pkg::BYTE_W;
  localparam int PIN_W = 2 * BW + hbc_pkg::RS_W + 8;
  localparam int CORE_W = 6;

  ////////////////////////////////////////////////////////////////////////////
  // Core clock side: launch flops and returning status.

  logic l_dma_req, l_dma_write, l_dio, l_dio_write, l_irq;
  logic [AW-1:0] l_addr;
  logic [BW-1:0] l_vector;
  logic [1:0] back_sync;
  logic owned_flag, iack_flag;

  // Core requests are registered so only clean flop outputs cross domains, apart from clk_en, which is synchronised unregistered.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      l_dma_req <= 1'h0;
      l_dma_write <= 1'h0;
      l_dio <= 1'h0;
      l_dio_write <= 1'h0;
      l_irq <= 1'h0;
      l_addr <= '0;
      l_vector <= hbc_pkg::BYTE_RST;
    end else if (clk_en) begin
      l_dma_req <= dma_req;
      l_dma_write <= dma_write;
      l_dio <= direct_io_access;
      l_dio_write <= dio_write;
      l_irq <= irq_pending;
      l_addr <= dma_addr;
      l_vector <= irq_vector;
    end
  end

  hbc_sync #(.W(2)) u_back_sync (
    .clk(ref_clk),
    .arst_n(arst_n),
    .d({owned_flag, iack_flag}),
    .q(back_sync)
  );

  // Bus ownership and vector delivery are reported back to the core.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      dma_granted <= 1'h0;
      irq_acked <= 1'h0;
    end else if (clk_en) begin
      dma_granted <= back_sync[1];
      irq_acked <= back_sync[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host bus side: synchronisers for pins and for core levels.

  logic [PIN_W-1:0] pin_q;
  logic [CORE_W-1:0] core_q;
  logic sy_hack, sy_iack_n, sy_strobe, sy_cs_n, sy_bhe_n, sy_style, sy_par_hi, sy_par_lo;
  logic [hbc_pkg::RS_W-1:0] sy_rs;
  logic [BW-1:0] sy_ad_hi, sy_ad_lo;
  logic sy_ce, sy_dma_req, sy_dma_wr, sy_dio, sy_dio_wr, sy_irq;

  hbc_sync #(.W(PIN_W)) u_pin_sync (
    .clk(host_bus_clock),
    .arst_n(arst_n),
    .d({hold_acknowledge_in, interrupt_acknowledge_in, address_strobe_in, chip_select_n,
        byte_high_enable_n, bus_style_strap, parity_high_lane_in, parity_low_lane_in,
        register_select_lines, addr_data_high_byte_in, addr_data_low_byte_in}),
    .q(pin_q)
  );

  hbc_sync #(.W(CORE_W)) u_core_sync (
    .clk(host_bus_clock),
    .arst_n(arst_n),
    .d({clk_en, l_dma_req, l_dma_write, l_dio, l_dio_write, l_irq}),
    .q(core_q)
  );

  // Acknowledge is only ever used after two flops.
  assign {sy_hack, sy_iack_n, sy_strobe, sy_cs_n, sy_bhe_n, sy_style, sy_par_hi, sy_par_lo,
          sy_rs, sy_ad_hi, sy_ad_lo} = pin_q;
  assign {sy_ce, sy_dma_req, sy_dma_wr, sy_dio, sy_dio_wr, sy_irq} = core_q;

  ////////////////////////////////////////////////////////////////////////////
  // Bus style strap, caught once after reset release.

  logic strap_taken;

  // The strap is sampled on the first enabled edge and then held.
  always_ff @(posedge host_bus_clock or negedge arst_n) begin
    if (!arst_n) begin
      strap_taken <= 1'h0;
      x86_mode <= 1'h0;
    end else if (sy_ce && !strap_taken) begin
      strap_taken <= 1'h1;
      x86_mode <= (sy_style == hbc_pkg::STYLE_X86);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus mastership sequence.

  hbc_pkg::hbc_state_t state, next_state;
  logic next_owned;

  // A request is made only in x86 style; ownership waits for the grant.
  always_comb begin
    next_state = state;
    case (state)
      hbc_pkg::HBC_IDLE: begin
        if (sy_dma_req && x86_mode) next_state = hbc_pkg::HBC_REQUEST;
      end
      hbc_pkg::HBC_REQUEST: begin
        if (sy_hack) next_state = hbc_pkg::HBC_LATCH;
        else if (!sy_dma_req) next_state = hbc_pkg::HBC_IDLE;
      end
      hbc_pkg::HBC_LATCH: next_state = hbc_pkg::HBC_TRANSFER;
      hbc_pkg::HBC_TRANSFER: begin
        if (!sy_dma_req || !sy_hack) next_state = hbc_pkg::HBC_RELEASE;
      end
      hbc_pkg::HBC_RELEASE: next_state = hbc_pkg::HBC_IDLE;
      default: next_state = hbc_pkg::HBC_IDLE;
    endcase
  end

  assign next_owned = (next_state == hbc_pkg::HBC_LATCH) || (next_state == hbc_pkg::HBC_TRANSFER);

  // State and the handshake pins all follow the next state, so pins come from flops.
  always_ff @(posedge host_bus_clock or negedge arst_n) begin
    if (!arst_n) begin
      state <= hbc_pkg::HBC_IDLE;
      hold_request_out <= 1'h0;
      bus_owned_n <= hbc_pkg::OWN_N_RST;
      address_latch_pulse <= 1'h0;
      owned_flag <= 1'h0;
    end else if (sy_ce) begin
      state <= next_state;
      hold_request_out <= next_owned || (next_state == hbc_pkg::HBC_REQUEST);
      bus_owned_n <= !next_owned;
      address_latch_pulse <= (next_state == hbc_pkg::HBC_LATCH);
      owned_flag <= next_owned;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data buffer direction.

  logic next_dir;

  // DMA decides while owned, then a direct access, otherwise output by default.
  always_comb begin
    if (next_owned) next_dir = sy_dma_wr ? hbc_pkg::DIR_OUT : hbc_pkg::DIR_IN;
    else if (sy_dio) next_dir = sy_dio_wr ? hbc_pkg::DIR_IN : hbc_pkg::DIR_OUT;
    else next_dir = hbc_pkg::DIR_OUT;
  end

  always_ff @(posedge host_bus_clock or negedge arst_n) begin
    if (!arst_n) buffer_direction_out <= hbc_pkg::DIR_RST;
    else if (sy_ce) buffer_direction_out <= next_dir;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt request, vector drive and lane parity.

  logic drive_vec, drive_addr;

  // In x86 style the vector goes out while the acknowledge is low and the bus is not ours.
  assign drive_addr = (next_state == hbc_pkg::HBC_LATCH);
  assign drive_vec = !sy_iack_n && !next_owned && x86_mode;

  always_ff @(posedge host_bus_clock or negedge arst_n) begin
    if (!arst_n) begin
      interrupt_request_out <= 1'h0;
      iack_flag <= 1'h0;
    end else if (sy_ce) begin
      interrupt_request_out <= sy_irq && x86_mode;
      iack_flag <= drive_vec;
    end
  end

  // Lanes carry the DMA address during the latch cycle or the vector on acknowledge.
  always_ff @(posedge host_bus_clock or negedge arst_n) begin
    if (!arst_n) begin
      addr_data_high_byte_out <= hbc_pkg::BYTE_RST;
      addr_data_low_byte_out <= hbc_pkg::BYTE_RST;
      parity_high_lane_out <= 1'h1;
      parity_low_lane_out <= 1'h1;
      lanes_oe_n <= hbc_pkg::OE_N_RST;
    end else if (sy_ce) begin
      lanes_oe_n <= !(drive_addr || drive_vec);
      if (drive_addr) begin
        addr_data_high_byte_out <= l_addr[AW-1 -: BW];
        addr_data_low_byte_out <= l_addr[BW-1:0];
        parity_high_lane_out <= ~^l_addr[AW-1 -: BW];
        parity_low_lane_out <= ~^l_addr[BW-1:0];
      end else if (drive_vec) begin
        addr_data_high_byte_out <= hbc_pkg::BYTE_RST;
        addr_data_low_byte_out <= l_vector;
        parity_high_lane_out <= ~^hbc_pkg::BYTE_RST;
        parity_low_lane_out <= ~^l_vector;
      end
    end
  end

  // Incoming bytes of a host write are checked for odd parity on each lane.
  always_ff @(posedge host_bus_clock or negedge arst_n) begin
    if (!arst_n) parity_error <= 1'h0;
    else if (sy_ce) parity_error <= sy_dio && sy_dio_wr && lanes_oe_n &&
                                    !((^{sy_ad_hi, sy_par_hi}) && (^{sy_ad_lo, sy_par_lo}));
  end

  ////////////////////////////////////////////////////////////////////////////
  // Select latch; the strobe pin is never driven by this block.

  // Transparent while the strobe is high, holding from its falling edge.
  always_ff @(posedge host_bus_clock or negedge arst_n) begin
    if (!arst_n) begin
      latched_cs_n <= hbc_pkg::CS_N_RST;
      latched_rs <= hbc_pkg::RS_RST;
      latched_bhe_n <= hbc_pkg::BHE_N_RST;
    end else if (sy_ce && sy_strobe) begin
      latched_cs_n <= sy_cs_n;
      latched_rs <= sy_rs;
      latched_bhe_n <= sy_bhe_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the host bus side.

  a_own_needs_ack: assert property (@(posedge host_bus_clock) disable iff (!arst_n)
    $fell(bus_owned_n) |-> $past(sy_hack) && hold_request_out)
    else $error("bus owned without hold acknowledge");

  a_req_covers_own: assert property (@(posedge host_bus_clock) disable iff (!arst_n)
    !bus_owned_n |-> hold_request_out)
    else $error("bus owned without hold request");

  a_ale_single: assert property (@(posedge host_bus_clock) disable iff (!arst_n)
    $rose(address_latch_pulse) |-> !bus_owned_n && !lanes_oe_n ##1 !address_latch_pulse)
    else $error("address latch pulse malformed");

  a_dir_idle: assert property (@(posedge host_bus_clock) disable iff (!arst_n)
    bus_owned_n && $past(sy_ce) && !$past(sy_dio) |-> buffer_direction_out)
    else $error("direction not high while idle");

  a_dir_dma: assert property (@(posedge host_bus_clock) disable iff (!arst_n)
    !bus_owned_n && $past(sy_ce) |-> buffer_direction_out == $past(sy_dma_wr))
    else $error("direction wrong during dma");

  a_dir_dio: assert property (@(posedge host_bus_clock) disable iff (!arst_n)
    bus_owned_n && $past(sy_ce) && $past(sy_dio) |-> buffer_direction_out == !$past(sy_dio_wr))
    else $error("direction wrong during direct access");

  a_vec_drive: assert property (@(posedge host_bus_clock) disable iff (!arst_n)
    $past(sy_ce) && $past(!sy_iack_n) && $past(x86_mode) && bus_owned_n |-> !lanes_oe_n)
    else $error("vector not driven on acknowledge");

  a_lane_parity: assert property (@(posedge host_bus_clock) disable iff (!arst_n)
    !lanes_oe_n |-> (^{addr_data_high_byte_out, parity_high_lane_out}) &&
                    (^{addr_data_low_byte_out, parity_low_lane_out}))
    else $error("driven lane parity not odd");

  a_irq_level: assert property (@(posedge host_bus_clock) disable iff (!arst_n)
    $past(sy_ce) |-> interrupt_request_out == $past(sy_irq && x86_mode))
    else $error("interrupt request does not follow pending");

  a_latch_hold: assert property (@(posedge host_bus_clock) disable iff (!arst_n)
    $past(sy_ce) && $past(!sy_strobe) |-> $stable(latched_cs_n) && $stable(latched_rs) && $stable(latched_bhe_n))
    else $error("select latch changed while strobe low");

  a_latch_open: assert property (@(posedge host_bus_clock) disable iff (!arst_n)
    $past(sy_ce && sy_strobe) |-> latched_cs_n == $past(sy_cs_n) && latched_rs == $past(sy_rs))
    else $error("select latch not transparent");

  a_style_gate: assert property (@(posedge host_bus_clock) disable iff (!arst_n)
    !x86_mode |-> bus_owned_n && !hold_request_out)
    else $error("bus activity outside x86 style");

endmodule : hbc_host_ctrl

// ==== hw/hbc_sync.sv ====
// Two-stage synchroniser for a group of independent levels.
// Assumes each bit is a level that stays put for several destination clocks.
`timescale 1ns/10ps
module hbc_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta;

  // The first stage is read only by the second stage.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule : hbc_sync

// ==== tb/hbc_host_model.sv ====
// Host side model: grants the bus hold and acknowledges interrupts.
// Assumes the device pins run on host_bus_clock with an active low reset.
`timescale 1ns/10ps
module hbc_host_model (
  input wire logic host_bus_clock,
  input wire logic arst_n,
  input wire logic hold_request_out,
  input wire logic interrupt_request_out,
  input wire logic [3:0] grant_delay,
  input wire logic iack_en,
  output logic hold_acknowledge_in,
  output logic interrupt_acknowledge_in
);
  logic [3:0] wait_cnt;

  ////////////////////////////////////////////////////////////
  // Grants the hold after a chosen delay and drops it once the request goes.
  always_ff @(posedge host_bus_clock or negedge arst_n) begin
    if (!arst_n) begin
      wait_cnt <= 4'h0;
      hold_acknowledge_in <= 1'h0;
    end else if (!hold_request_out) begin
      wait_cnt <= 4'h0;
      hold_acknowledge_in <= 1'h0;
    end else if (wait_cnt == grant_delay) begin
      hold_acknowledge_in <= 1'h1;
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end

  // Acknowledges a pending request only while the bench allows it.
  always_ff @(posedge host_bus_clock or negedge arst_n) begin
    if (!arst_n) begin
      interrupt_acknowledge_in <= 1'h1;
    end else begin
      interrupt_acknowledge_in <= !(interrupt_request_out && iack_en);
    end
  end
endmodule : hbc_host_model

// ==== tb/tb.sv ====
// Self-checking bench for the host bus control block.
// Assumes the host model answers holds and interrupt acknowledges.
`timescale 1ns/10ps
module tb;
  logic ref_clk, arst_n, clk_en, host_bus_clock, strap, hack, iack_n, iack_en;
  logic dma_req, dma_write, direct_io_access, dio_write, irq_pending;
  logic [15:0] dma_addr;
  logic [7:0] irq_vector, hi_in, lo_in, hi_out, lo_out;
  logic strobe, cs_n, bhe_n, ph_in, pl_in, ph_out, pl_out;
  logic [3:0] rs, l_rs, grant_delay;
  logic oe_n, dir, hreq, ireq, own_n, alp, x86, perr, l_cs_n, l_bhe_n, granted, acked;
  int errors, samples_checked;

  ////////////////////////////////////////////////////////////
  // Device under test and the host on its far side.
  hbc_host_ctrl DUT (.ref_clk(ref_clk), .arst_n(arst_n), .clk_en(clk_en),
    .host_bus_clock(host_bus_clock), .dma_req(dma_req), .dma_write(dma_write),
    .dma_addr(dma_addr), .direct_io_access(direct_io_access), .dio_write(dio_write),
    .irq_pending(irq_pending), .irq_vector(irq_vector), .dma_granted(granted),
    .irq_acked(acked), .bus_style_strap(strap), .hold_acknowledge_in(hack),
    .interrupt_acknowledge_in(iack_n), .address_strobe_in(strobe), .chip_select_n(cs_n),
    .register_select_lines(rs), .byte_high_enable_n(bhe_n), .addr_data_high_byte_in(hi_in),
    .addr_data_low_byte_in(lo_in), .parity_high_lane_in(ph_in), .parity_low_lane_in(pl_in),
    .addr_data_high_byte_out(hi_out), .addr_data_low_byte_out(lo_out),
    .parity_high_lane_out(ph_out), .parity_low_lane_out(pl_out), .lanes_oe_n(oe_n),
    .buffer_direction_out(dir), .hold_request_out(hreq), .interrupt_request_out(ireq),
    .bus_owned_n(own_n), .address_latch_pulse(alp), .x86_mode(x86), .parity_error(perr),
    .latched_cs_n(l_cs_n), .latched_rs(l_rs), .latched_bhe_n(l_bhe_n));
  hbc_host_model HOST (.host_bus_clock(host_bus_clock), .arst_n(arst_n),
    .hold_request_out(hreq), .interrupt_request_out(ireq), .grant_delay(grant_delay),
    .iack_en(iack_en), .hold_acknowledge_in(hack), .interrupt_acknowledge_in(iack_n));

  ////////////////////////////////////////////////////////////
  // Two unrelated clocks: core at 10 ns, host bus at 6 ns.
  initial begin
    ref_clk = 1'h0;
    forever #5 ref_clk = !ref_clk;
  end
  initial begin
    host_bus_clock = 1'h0;
    #1.7;
    forever #3 host_bus_clock = !host_bus_clock;
  end

  // Compares one value and counts the outcome.
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Lets host edges pass, then steps off the edge.
  task automatic hb(input int n);
    repeat (n) @(posedge host_bus_clock);
    #1;
  endtask : hb

  // Steps just past a core edge before inputs change.
  task automatic go();
    @(posedge ref_clk);
    #1;
  endtask : go

  task automatic conclude();
    if (errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude

  ////////////////////////////////////////////////////////////
  // Idle levels once the strap has been taken.
  task automatic t_idle();
    chk("x86_mode", x86, 1'h1);
    chk("direction idle", dir, 1'h1);
    chk("hold request idle", hreq, 1'h0);
    chk("owned idle", own_n, 1'h1);
    chk("irq idle", ireq, 1'h0);
  endtask : t_idle

  // Host direct writes and reads, with a bad parity byte in the write.
  task automatic t_dio();
    go();
    direct_io_access = 1'h1;
    dio_write = 1'h1;
    hb(8);
    chk("direction dio write", dir, 1'h0);
    chk("parity good", perr, 1'h0);
    go();
    pl_in = 1'h0;
    hb(8);
    chk("parity bad", perr, 1'h1);
    go();
    pl_in = 1'h1;
    dio_write = 1'h0;
    hb(8);
    chk("direction dio read", dir, 1'h1);
    chk("parity clear", perr, 1'h0);
    go();
    direct_io_access = 1'h0;
  endtask : t_dio

  // One DMA ownership with a chosen grant delay.
  task automatic t_dma(input logic wr, input logic [3:0] dly, input logic [15:0] a);
    int n;
    go();
    grant_delay = dly;
    dma_write = wr;
    dma_addr = a;
    dma_req = 1'h1;
    for (n = 0; n < 20 && hreq !== 1'h1; n++) hb(1);
    chk("hold request", hreq, 1'h1);
    chk("owned before grant", own_n, 1'h1);
    for (n = 0; n < 40 && alp !== 1'h1; n++) hb(1);
    chk("latch pulse", alp, 1'h1);
    chk("owned", own_n, 1'h0);
    chk("address lanes", {hi_out, lo_out}, a);
    chk("parity lanes", {ph_out, pl_out}, {~^a[15:8], ~^a[7:0]});
    chk("lanes driven", oe_n, 1'h0);
    hb(1);
    chk("pulse width", alp, 1'h0);
    chk("direction dma", dir, wr);
    hb(8);
    chk("granted", granted, 1'h1);
    go();
    dma_req = 1'h0;
    hb(10);
    chk("request dropped", hreq, 1'h0);
    chk("owned released", own_n, 1'h1);
    chk("direction after dma", dir, 1'h1);
  endtask : t_dma

  // Interrupt request, held back acknowledge, then the vector.
  task automatic t_irq();
    go();
    irq_vector = 8'h3D;
    irq_pending = 1'h1;
    hb(8);
    chk("irq raised", ireq, 1'h1);
    chk("no vector yet", oe_n, 1'h1);
    go();
    iack_en = 1'h1;
    hb(12);
    chk("vector driven", oe_n, 1'h0);
    chk("vector lanes", {hi_out, lo_out}, {8'h00, 8'h3D});
    chk("vector parity", {ph_out, pl_out}, {1'h1, ~^8'h3D});
    chk("acked", acked, 1'h1);
    go();
    iack_en = 1'h0;
    irq_pending = 1'h0;
    hb(8);
    chk("vector released", oe_n, 1'h1);
    chk("irq dropped", ireq, 1'h0);
  endtask : t_irq

  // Select latch follows a high strobe and holds while it is low.
  task automatic t_latch();
    go();
    cs_n = 1'h0;
    rs = 4'hA;
    bhe_n = 1'h0;
    hb(6);
    chk("transparent", {l_cs_n, l_rs, l_bhe_n}, {1'h0, 4'hA, 1'h0});
    go();
    strobe = 1'h0;
    hb(2);
    go();
    cs_n = 1'h1;
    rs = 4'h5;
    bhe_n = 1'h1;
    hb(6);
    chk("held", {l_cs_n, l_rs, l_bhe_n}, {1'h0, 4'hA, 1'h0});
    go();
    strobe = 1'h1;
    hb(6);
    chk("reopened", {l_cs_n, l_rs, l_bhe_n}, {1'h1, 4'h5, 1'h1});
  endtask : t_latch

  // A low clock enable freezes both sides until it returns.
  task automatic t_freeze();
    go();
    clk_en = 1'h0;
    hb(8);
    go();
    irq_pending = 1'h1;
    hb(12);
    chk("frozen irq", ireq, 1'h0);
    go();
    clk_en = 1'h1;
    hb(12);
    chk("thawed irq", ireq, 1'h1);
    go();
    irq_pending = 1'h0;
    hb(8);
    chk("irq after thaw", ireq, 1'h0);
  endtask : t_freeze

  // A fresh reset with the strap low leaves the block passive.
  task automatic t_style();
    go();
    arst_n = 1'h0;
    strap = 1'h0;
    hb(6);
    go();
    arst_n = 1'h1;
    hb(10);
    chk("x86_mode low strap", x86, 1'h0);
    go();
    dma_req = 1'h1;
    irq_pending = 1'h1;
    iack_en = 1'h1;
    hb(12);
    chk("no request low strap", hreq, 1'h0);
    chk("not owned low strap", own_n, 1'h1);
    chk("no irq low strap", ireq, 1'h0);
    chk("no vector low strap", oe_n, 1'h1);
    go();
    dma_req = 1'h0;
    irq_pending = 1'h0;
    iack_en = 1'h0;
  endtask : t_style

  ////////////////////////////////////////////////////////////
  // Cuts a hang short.
  initial begin
    #100000;
    errors++;
    conclude();
  end

  // Main sequence.
  initial begin
    errors = 0;
    samples_checked = 0;
    arst_n = 1'h0;
    clk_en = 1'h1;
    strap = 1'h1;
    iack_en = 1'h0;
    grant_delay = 4'h0;
    dma_req = 1'h0;
    dma_write = 1'h0;
    dma_addr = 16'h0000;
    direct_io_access = 1'h0;
    dio_write = 1'h0;
    irq_pending = 1'h0;
    irq_vector = 8'h00;
    strobe = 1'h1;
    cs_n = 1'h1;
    rs = 4'h0;
    bhe_n = 1'h1;
    hi_in = 8'h00;
    lo_in = 8'h00;
    ph_in = 1'h1;
    pl_in = 1'h1;
    repeat (16) @(posedge ref_clk);
    #1;
    arst_n = 1'h1;
    hb(10);
    t_idle();
    t_dio();
    t_dma(1'h1, 4'h6, 16'hA5C3);
    t_dma(1'h0, 4'h0, 16'h8001);
    t_irq();
    t_latch();
    t_freeze();
    t_style();
    conclude();
  end
endmodule : tb
